// ---- hw/hw_monitor_irq_control.sv ----
// module: configuration, interrupt status, mask and alert logic of the hardware monitor
// Summary of operation
// R1: config bit 0 runs monitor, zero standby
// R2: clearing run never releases interrupt outputs
// R3: run starts channel scanning and limit compare
// R4: host programs limits before setting run
// R5: config bit 1 enables active-low alert output
// R6: bit 3 releases alert, pauses monitoring
// R7: bit 4 gives 45 ms low reset pulse
// R8: bit 6 releases over-temperature output only
// R9: bit 7 restores defaults and self-clears
// R10: status one bits flag channel limit violations
// R11: temperature interrupts also set bits 4, 5
// R12: status two flags 12 V, core two
// R13: status two bit 4 on chassis intrusion
// R14: bit 5 when overtemp pin pulled low
// R15: bits 6, 7 flag diode faults
// R16: reading status clears the returned bits
// R17: still-violating channels raise a new indication
// R18: mask one bit blocks status from alert
// R19: host masks repeating voltage interrupts
// R20: alert latches on unmasked status until cleared
module hw_monitor_irq_control
    import monitor_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] limit_one,
    input wire logic [1:0] limit_two,
    input wire logic [1:0] temp_irq,
    input wire logic diode_one_fault,
    input wire logic diode_two_fault,
    input wire logic overtemp_condition,
    input wire logic chassis_pin,
    input wire logic overtemp_pin_n_in,
    output logic overtemp_pin_n_out_q,
    output logic overtemp_pin_n_oe_n_q,
    output logic [7:0] reg_rdata_q,
    output logic reg_ack_q,
    output logic alert_n_q,
    output logic reset_out_n_q,
    output logic monitor_run_q
);

    logic [7:0] cfg_q;
    logic [7:0] status_one_q;
    logic [7:0] status_one_d;
    logic [7:0] status_two_q;
    logic [7:0] status_two_d;
    logic [7:0] mask_one_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic [1:0] pin_stable_q;
    logic chassis_seen_q;
    logic [3:0] drive_hist_q;
    logic alert_hold_q;
    logic overtemp_hold_q;
    logic pulse_busy;
    logic cfg_wr;
    logic init_wr;
    logic release_wr;
    logic pulse_wr;
    logic rd_one;
    logic rd_two;
    logic monitor_active;
    logic chassis_rise;
    logic external_pull;
    logic alert_pending;
    logic [7:0] set_one;
    logic [7:0] set_two;

    ////////////////////////////////////////////////////////////////////////////////
    // access decode
    assign cfg_wr = reg_wr && (reg_addr == CFG_ONE_ADDR);
    assign init_wr = cfg_wr && reg_wdata[CFG_INIT_BIT]; // R9
    assign release_wr = cfg_wr && reg_wdata[CFG_OVERTEMP_RELEASE_BIT];
    assign pulse_wr = cfg_wr && reg_wdata[CFG_RESET_PULSE_BIT] && !init_wr;
    assign rd_one = reg_rd && (reg_addr == STATUS_ONE_ADDR);
    assign rd_two = reg_rd && (reg_addr == STATUS_TWO_ADDR);

    // monitoring needs run and stops while the alert clear is held
    assign monitor_active = cfg_q[CFG_RUN_BIT] && !cfg_q[CFG_INT_CLEAR_BIT]; // R1 R3 R6

    ////////////////////////////////////////////////////////////////////////////////
    // configuration; strobe bits are never stored, so they self-clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_q <= CFG_ONE_RESET; // R1 R5 R6
        end else if (init_wr) begin
            cfg_q <= CFG_ONE_RESET; // R9
        end else if (cfg_wr) begin
            cfg_q <= reg_wdata & CFG_STORE_MASK;
        end
    end

    // mask one; the host uses it to silence a repeating channel
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mask_one_q <= MASK_ONE_RESET;
        end else if (init_wr) begin
            mask_one_q <= MASK_ONE_RESET; // R9
        end else if (reg_wr && (reg_addr == MASK_ONE_ADDR)) begin
            mask_one_q <= reg_wdata; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: the value moves once stages two and three agree
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pin_sync
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    pin_s1_q[i] <= (i == 1);
                    pin_s2_q[i] <= (i == 1);
                    pin_s3_q[i] <= (i == 1);
                    pin_stable_q[i] <= (i == 1); // idle levels, no false edge after reset
                end else begin
                    pin_s1_q[i] <= (i == 0) ? chassis_pin : overtemp_pin_n_in;
                    pin_s2_q[i] <= pin_s1_q[i];
                    pin_s3_q[i] <= pin_s2_q[i];
                    if (pin_s2_q[i] == pin_s3_q[i]) begin
                        pin_stable_q[i] <= pin_s3_q[i];
                    end
                end
            end
        end
    endgenerate

    // chassis edge memory and our own recent drive of the overtemp pin
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            chassis_seen_q <= 1'b0;
            drive_hist_q <= 4'h0;
        end else begin
            chassis_seen_q <= pin_stable_q[0];
            drive_hist_q <= {drive_hist_q[2:0], ~overtemp_pin_n_oe_n_q};
        end
    end

    assign chassis_rise = pin_stable_q[0] && !chassis_seen_q; // R13
    // ignore our own low until the synchroniser has flushed it
    assign external_pull = !pin_stable_q[1] && (drive_hist_q == 4'h0) &&
        !overtemp_hold_q; // R14

    ////////////////////////////////////////////////////////////////////////////////
    // status set terms; comparator inputs are levels, so a channel still out
    // of limits keeps its bit set through a read, since the set wins over the clear
    always_comb begin
        set_one = limit_one & {8{monitor_active}}; // R3 R10 R17
        set_one[ST1_INT_TEMP_BIT] = set_one[ST1_INT_TEMP_BIT] ||
            (temp_irq[0] && monitor_active); // R11
        set_one[ST1_REMOTE_TEMP_BIT] = set_one[ST1_REMOTE_TEMP_BIT] ||
            (temp_irq[1] && monitor_active); // R11
        set_two = 8'h00;
        set_two[ST2_SUPPLY_12V_BIT] = limit_two[0] && monitor_active; // R12
        set_two[ST2_CORE_TWO_BIT] = limit_two[1] && monitor_active; // R12
        set_two[ST2_CHASSIS_BIT] = chassis_rise; // R13
        set_two[ST2_OVERTEMP_IN_BIT] = external_pull; // R14
        set_two[ST2_DIODE_ONE_BIT] = diode_one_fault && monitor_active; // R15
        set_two[ST2_DIODE_TWO_BIT] = diode_two_fault && monitor_active; // R15
    end

    // read clears only what it returned; a set in the same cycle wins
    always_comb begin
        status_one_d = (status_one_q & ~(rd_one ? status_one_q : 8'h00)) | set_one; // R16
        status_two_d = (status_two_q & ~(rd_two ? status_two_q : 8'h00)) | set_two; // R16
        if (init_wr) begin
            status_one_d = STATUS_RESET; // R9
            status_two_d = STATUS_RESET; // R9
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_one_q <= STATUS_RESET;
            status_two_q <= STATUS_RESET;
        end else begin
            status_one_q <= status_one_d;
            status_two_q <= status_two_d & ST2_VALID_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // alert latch; run going low is not a release path
    assign alert_pending = ((status_one_q & ~mask_one_q) != 8'h00) || // R18
        (status_two_q != 8'h00);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            alert_hold_q <= 1'b0;
        end else if (init_wr || cfg_q[CFG_INT_CLEAR_BIT]) begin
            alert_hold_q <= 1'b0; // R2 R6
        end else if (alert_pending && cfg_q[CFG_ALERT_EN_BIT]) begin
            alert_hold_q <= 1'b1; // R20
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            alert_n_q <= 1'b1;
            monitor_run_q <= 1'b0;
        end else begin
            alert_n_q <= !(alert_hold_q && cfg_q[CFG_ALERT_EN_BIT]); // R5
            monitor_run_q <= monitor_active; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // over-temperature output; a live condition beats the release
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            overtemp_hold_q <= 1'b0;
        end else if (overtemp_condition && cfg_q[CFG_OVERTEMP_EN_BIT]) begin
            overtemp_hold_q <= 1'b1;
        end else if (release_wr || init_wr) begin
            overtemp_hold_q <= 1'b0; // R8
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            overtemp_pin_n_out_q <= 1'b0;
            overtemp_pin_n_oe_n_q <= 1'b1;
        end else begin
            overtemp_pin_n_out_q <= 1'b0;
            overtemp_pin_n_oe_n_q <= !overtemp_hold_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset pulse; the busy flag doubles as the readable bit 4
    pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_reset_pulse (
        .core_clk(core_clk),
        .reset(reset),
        .start(pulse_wr), // R7
        .busy_q(pulse_busy)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reset_out_n_q <= 1'b1;
        end else begin
            reset_out_n_q <= !pulse_busy; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read port; data is sampled before the read clears it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= READ_UNMAPPED;
            reg_ack_q <= 1'b0;
        end else begin
            reg_ack_q <= reg_rd || reg_wr;
            if (reg_rd) begin
                case (reg_addr)
                    CFG_ONE_ADDR: begin
                        reg_rdata_q <= cfg_q | {3'h0, pulse_busy, 4'h0};
                    end
                    STATUS_ONE_ADDR: begin
                        reg_rdata_q <= status_one_q;
                    end
                    STATUS_TWO_ADDR: begin
                        reg_rdata_q <= status_two_q;
                    end
                    MASK_ONE_ADDR: begin
                        reg_rdata_q <= mask_one_q;
                    end
                    default: begin
                        reg_rdata_q <= READ_UNMAPPED;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_run_starts_scan: assert property ( // R1
        cfg_wr && reg_wdata[CFG_RUN_BIT] && !reg_wdata[CFG_INT_CLEAR_BIT] &&
        !reg_wdata[CFG_INIT_BIT] ##1 !cfg_wr |=> monitor_run_q)
        else $error("run bit did not start monitoring");

    chk_run_keeps_alert: assert property ( // R2
        cfg_wr && !reg_wdata[CFG_INIT_BIT] && !reg_wdata[CFG_INT_CLEAR_BIT] &&
        !cfg_q[CFG_INT_CLEAR_BIT] && alert_hold_q |=> alert_hold_q)
        else $error("alert released by a plain configuration write");

    chk_alert_enable_gate: assert property ( // R5
        !cfg_q[CFG_ALERT_EN_BIT] |=> alert_n_q)
        else $error("alert driven while disabled");

    chk_clear_pauses: assert property ( // R6
        cfg_q[CFG_INT_CLEAR_BIT] |=> !alert_hold_q && !monitor_run_q)
        else $error("alert clear did not release or pause");

    chk_reset_pulse_low: assert property ( // R7
        pulse_wr && !pulse_busy |=> ##1 !reset_out_n_q [*3])
        else $error("reset pulse did not start low");

    chk_overtemp_release: assert property ( // R8
        release_wr && !overtemp_condition |=> overtemp_pin_n_oe_n_q == $past(overtemp_pin_n_oe_n_q)
        ##1 overtemp_pin_n_oe_n_q)
        else $error("overtemp output not released");

    chk_init_defaults: assert property ( // R9
        init_wr |=> cfg_q == CFG_ONE_RESET && mask_one_q == MASK_ONE_RESET &&
        status_one_q == STATUS_RESET && status_two_q == STATUS_RESET)
        else $error("initialise did not restore defaults");

    chk_limit_sets: assert property ( // R10
        monitor_active && !init_wr && limit_one != 8'h00 |=>
        (status_one_q & $past(limit_one)) == $past(limit_one))
        else $error("limit violation not latched");

    chk_read_clears: assert property ( // R16
        rd_one && !init_wr && set_one == 8'h00 |=> status_one_q == 8'h00 &&
        reg_rdata_q == $past(status_one_q))
        else $error("status read did not return and clear");

    chk_chassis_sets: assert property ( // R13
        chassis_rise && !init_wr |=> status_two_q[ST2_CHASSIS_BIT])
        else $error("chassis intrusion not latched");

    chk_mask_blocks: assert property ( // R18
        !alert_pending && !alert_hold_q |=> !alert_hold_q)
        else $error("masked status raised the alert");

    chk_alert_latches: assert property ( // R20
        alert_pending && cfg_q[CFG_ALERT_EN_BIT] && !cfg_q[CFG_INT_CLEAR_BIT] &&
        !init_wr |=> alert_hold_q)
        else $error("unmasked status did not raise the alert");

    cov_alert_raised: cover property (alert_hold_q && !alert_n_q);
    cov_reset_pulse: cover property ($fell(reset_out_n_q));
    cov_read_clear: cover property (rd_one && status_one_q != 8'h00);

endmodule // hw_monitor_irq_control

// ---- hw/monitor_pkg.sv ----
// package: register map, field positions, reset values and timing of the monitor control block
package monitor_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets on the management register port
    localparam logic [7:0] CFG_ONE_ADDR = 8'h40;
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0] MASK_ONE_ADDR = 8'h43;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration field positions
    localparam int CFG_RUN_BIT = 0;
    localparam int CFG_ALERT_EN_BIT = 1;
    localparam int CFG_OVERTEMP_EN_BIT = 2;
    localparam int CFG_INT_CLEAR_BIT = 3;
    localparam int CFG_RESET_PULSE_BIT = 4;
    localparam int CFG_OVERTEMP_RELEASE_BIT = 6;
    localparam int CFG_INIT_BIT = 7;

    // bits held in the configuration flops; 4, 6 and 7 are strobes
    localparam logic [7:0] CFG_STORE_MASK = 8'h2F;

    ////////////////////////////////////////////////////////////////////////////////
    // status two field positions
    localparam int ST2_SUPPLY_12V_BIT = 0;
    localparam int ST2_CORE_TWO_BIT = 1;
    localparam int ST2_CHASSIS_BIT = 4;
    localparam int ST2_OVERTEMP_IN_BIT = 5;
    localparam int ST2_DIODE_ONE_BIT = 6;
    localparam int ST2_DIODE_TWO_BIT = 7;
    localparam logic [7:0] ST2_VALID_MASK = 8'hF3;

    // status one bits that temperature interrupts also set
    localparam int ST1_INT_TEMP_BIT = 4;
    localparam int ST1_REMOTE_TEMP_BIT = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CFG_ONE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_ONE_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int RESET_PULSE_MS = 45;
    localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * (CORE_CLK_HZ / 1000);

endpackage

// ---- hw/pulse_timer.sv ----
// module: fixed-length pulse generator for the programmable reset output
module pulse_timer #(
    parameter int CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    output logic busy_q
);

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_q;

    // refuse lengths that cannot form a pulse
    if (CYCLES < 1) begin : g_cycles_check
        $error("pulse_timer: CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // start while busy is ignored, so a repeat write cannot stretch the pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
            count_q <= '0;
        end else if (!busy_q) begin
            busy_q <= start;
            count_q <= '0;
        end else if (count_q == LAST) begin
            busy_q <= 1'b0;
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

endmodule // pulse_timer

// ---- test/board_model.sv ----
// board side of the monitor: pulled-up overtemp wire, external pull and reset pulse meter
module board_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic overtemp_pin_n_out_q,
    input wire logic overtemp_pin_n_oe_n_q,
    input wire logic reset_out_n_q,
    input wire logic ext_pull,
    output logic overtemp_pin_n_in,
    output logic [31:0] low_len_q
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain wire: pull-up wins unless the block or the external agent pulls low
    assign overtemp_pin_n_in = !ext_pull && (overtemp_pin_n_oe_n_q || overtemp_pin_n_out_q);

    // length of the latest low pulse on the reset output, restarted on each fall
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prev_n_q <= 1'b1;
            low_len_q <= 32'h0;
        end else begin
            prev_n_q <= reset_out_n_q;
            if (!reset_out_n_q) begin
                low_len_q <= prev_n_q ? 32'h1 : low_len_q + 32'h1;
            end
        end
    end
endmodule // board_model

// ---- test/test_hw_monitor_irq_control.sv ----
// self-checking bench of the monitor control block, driven over its register strobe port
module test_hw_monitor_irq_control;
    import monitor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PULSE = 8;
    logic core_clk, reset, reg_wr, reg_rd, d1, d2, ot_cond, chassis_pin, ext_pull;
    logic [7:0] reg_addr, reg_wdata, limit_one, reg_rdata_q;
    logic [1:0] limit_two, temp_irq;
    logic ot_in, ot_out_q, ot_oe_n_q, reg_ack_q, alert_n_q, reset_out_n_q, monitor_run_q;
    logic [31:0] low_len_q;
    int err_total, check_count, cycles;

    hw_monitor_irq_control #(.PULSE_CYCLES(PULSE)) i_hw_monitor_irq_control (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .limit_one(limit_one), .limit_two(limit_two),
        .temp_irq(temp_irq), .diode_one_fault(d1), .diode_two_fault(d2),
        .overtemp_condition(ot_cond), .chassis_pin(chassis_pin), .overtemp_pin_n_in(ot_in),
        .overtemp_pin_n_out_q(ot_out_q), .overtemp_pin_n_oe_n_q(ot_oe_n_q),
        .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q), .alert_n_q(alert_n_q),
        .reset_out_n_q(reset_out_n_q), .monitor_run_q(monitor_run_q));

    board_model i_board_model (
        .core_clk(core_clk), .reset(reset), .overtemp_pin_n_out_q(ot_out_q),
        .overtemp_pin_n_oe_n_q(ot_oe_n_q), .reset_out_n_q(reset_out_n_q),
        .ext_pull(ext_pull), .overtemp_pin_n_in(ot_in), .low_len_q(low_len_q));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, and a hang guard well above the few hundred cycles the tests need
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask

    // time always rests 1 ns after a rising edge, so drives never race the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one strobe cycle, answer checked at the ack cycle; a spare cycle keeps strobes apart
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = !wr;
        tick(1);
        check("ack", {7'h00, reg_ack_q}, 8'h01);
        rdata = reg_rdata_q;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tick(1);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        access(1'b1, addr, data, unused);
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        access(1'b0, addr, 8'h00, got);
        check($sformatf("reg %h", addr), got, exp);
    endtask

    // one cycle of engine levels, then time for the status flops to take them
    task automatic levels(input logic [7:0] l1, input logic [1:0] l2, input logic [1:0] ti,
                          input logic f1, input logic f2);
        limit_one = l1;
        limit_two = l2;
        temp_irq = ti;
        d1 = f1;
        d2 = f2;
        tick(1);
        {limit_one, limit_two, temp_irq, d1, d2} = 14'h0;
        tick(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; engine levels driven before run is set must not land in status
    initial begin
        {reset, reg_wr, reg_rd, d1, d2, ot_cond, chassis_pin, ext_pull} = 8'h80;
        {reg_addr, reg_wdata, limit_one, limit_two, temp_irq} = 28'h0;
        err_total = 0;
        check_count = 0;
        cycles = 0;
        repeat (12) @(posedge core_clk);
        #1;
        reset = 1'b0;
        tick(1);
        check("pins", {4'h0, alert_n_q, reset_out_n_q, ot_oe_n_q, monitor_run_q}, 8'h0E);
        rd(CFG_ONE_ADDR, 8'h00);
        rd(STATUS_ONE_ADDR, 8'h00);
        rd(STATUS_TWO_ADDR, 8'h00);
        rd(MASK_ONE_ADDR, 8'h00);
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'h00);
        wr(STATUS_ONE_ADDR, 8'hFF);
        // standby ignores limit levels
        levels(8'h04, 2'h0, 2'h0, 1'b0, 1'b0);
        rd(STATUS_ONE_ADDR, 8'h00);
        wr(CFG_ONE_ADDR, 8'h23);
        rd(CFG_ONE_ADDR, 8'h23);
        check("run", {7'h00, monitor_run_q}, 8'h01);
        wr(CFG_ONE_ADDR, 8'h03);
        levels(8'h02, 2'h0, 2'h0, 1'b0, 1'b0);
        tick(3);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        wr(CFG_ONE_ADDR, 8'h02);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        wr(CFG_ONE_ADDR, 8'h0B);
        tick(1);
        check("alert", {7'h00, alert_n_q}, 8'h01);
        check("run", {7'h00, monitor_run_q}, 8'h00);
        // paused: this level must not land, and status one stays unread
        levels(8'h04, 2'h0, 2'h0, 1'b0, 1'b0);
        rd(CFG_ONE_ADDR, 8'h0B);
        wr(CFG_ONE_ADDR, 8'h03);
        tick(4);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        rd(STATUS_ONE_ADDR, 8'h02);
        rd(STATUS_ONE_ADDR, 8'h00);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        // alert enable low keeps the pin quiet
        wr(CFG_ONE_ADDR, 8'h09);
        wr(CFG_ONE_ADDR, 8'h01);
        levels(8'h08, 2'h0, 2'h0, 1'b0, 1'b0);
        tick(3);
        check("alert", {7'h00, alert_n_q}, 8'h01);
        rd(STATUS_ONE_ADDR, 8'h08);
        // host masks a repeating channel
        wr(MASK_ONE_ADDR, 8'h01);
        rd(MASK_ONE_ADDR, 8'h01);
        wr(CFG_ONE_ADDR, 8'h03);
        levels(8'h01, 2'h0, 2'h0, 1'b0, 1'b0);
        tick(3);
        check("alert", {7'h00, alert_n_q}, 8'h01);
        rd(STATUS_ONE_ADDR, 8'h01);
        levels(8'h02, 2'h0, 2'h0, 1'b0, 1'b0);
        tick(3);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        rd(STATUS_ONE_ADDR, 8'h02);
        // every status bit from its own source
        for (int i = 0; i < 8; i++) begin
            levels(8'h01 << i, 2'h0, 2'h0, 1'b0, 1'b0);
            rd(STATUS_ONE_ADDR, 8'h01 << i);
        end
        levels(8'h00, 2'h0, 2'h1, 1'b0, 1'b0);
        rd(STATUS_ONE_ADDR, 8'h10);
        levels(8'h00, 2'h0, 2'h2, 1'b0, 1'b0);
        rd(STATUS_ONE_ADDR, 8'h20);
        levels(8'h00, 2'h1, 2'h0, 1'b0, 1'b0);
        rd(STATUS_TWO_ADDR, 8'h01);
        levels(8'h00, 2'h2, 2'h0, 1'b0, 1'b0);
        rd(STATUS_TWO_ADDR, 8'h02);
        levels(8'h00, 2'h0, 2'h0, 1'b1, 1'b0);
        rd(STATUS_TWO_ADDR, 8'h40);
        levels(8'h00, 2'h0, 2'h0, 1'b0, 1'b1);
        rd(STATUS_TWO_ADDR, 8'h80);
        chassis_pin = 1'b1;
        tick(8);
        rd(STATUS_TWO_ADDR, 8'h10);
        rd(STATUS_TWO_ADDR, 8'h00);
        ext_pull = 1'b1;
        tick(8);
        rd(STATUS_TWO_ADDR, 8'h20);
        ext_pull = 1'b0;
        tick(8);
        rd(STATUS_TWO_ADDR, 8'h20);
        rd(STATUS_TWO_ADDR, 8'h00);
        // two channels still out of limits come back after a read
        limit_one = 8'h03;
        tick(2);
        rd(STATUS_ONE_ADDR, 8'h03);
        rd(STATUS_ONE_ADDR, 8'h03);
        limit_one = 8'h00;
        tick(3);
        rd(STATUS_ONE_ADDR, 8'h03);
        rd(STATUS_ONE_ADDR, 8'h00);
        // over-temperature drive, then release without touching status
        wr(CFG_ONE_ADDR, 8'h05);
        ot_cond = 1'b1;
        tick(1);
        ot_cond = 1'b0;
        tick(3);
        check("ot out oe_n", {6'h00, ot_out_q, ot_oe_n_q}, 8'h00);
        wr(CFG_ONE_ADDR, 8'h45);
        tick(1);
        check("ot out oe_n", {6'h00, ot_out_q, ot_oe_n_q}, 8'h01);
        rd(CFG_ONE_ADDR, 8'h05);
        rd(STATUS_TWO_ADDR, 8'h00);
        // reset pulse length and self-clearing strobe
        wr(CFG_ONE_ADDR, 8'h10);
        rd(CFG_ONE_ADDR, 8'h10);
        tick(PULSE + 4);
        check("pulse len", low_len_q[7:0], 8'(PULSE));
        check("reset_out", {7'h00, reset_out_n_q}, 8'h01);
        rd(CFG_ONE_ADDR, 8'h00);
        // our own released drive must not read back as an external pull
        rd(STATUS_TWO_ADDR, 8'h00);
        // initialise with run, alert, mask and status one armed
        wr(CFG_ONE_ADDR, 8'h23);
        wr(MASK_ONE_ADDR, 8'h0F);
        levels(8'h30, 2'h0, 2'h0, 1'b0, 1'b0);
        tick(3);
        check("alert", {7'h00, alert_n_q}, 8'h00);
        wr(CFG_ONE_ADDR, 8'h80);
        check("pins", {6'h00, alert_n_q, monitor_run_q}, 8'h02);
        rd(CFG_ONE_ADDR, 8'h00);
        rd(MASK_ONE_ADDR, 8'h00);
        rd(STATUS_ONE_ADDR, 8'h00);
        give_verdict();
    end
endmodule // test_hw_monitor_irq_control
